// ===== core/asu_defines.svh
// Offsets, field positions, reset values and codes of the async serial unit
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ASU_OFS_MODE 16'hFF50
`define ASU_OFS_RXB 16'hFF51
`define ASU_OFS_ERR 16'hFF53
`define ASU_OFS_TXST 16'hFF54
`define ASU_OFS_TXB 16'hFF55
`define ASU_OFS_DIV 16'hFF56
`define ASU_OFS_CTRL 16'hFF58

// ****************************************
// Field positions
// ****************************************
`define ASU_MODE_POWER 7
`define ASU_MODE_TXE 6
`define ASU_MODE_RXE 5
`define ASU_MODE_PSH 4
`define ASU_MODE_PSL 3
`define ASU_MODE_CL 2
`define ASU_MODE_SL 1
`define ASU_CTRL_BRF 7
`define ASU_CTRL_BRT 6
`define ASU_CTRL_DIR 1
`define ASU_CTRL_INV 0
`define ASU_ERR_PE 2
`define ASU_ERR_FE 1
`define ASU_ERR_OVE 0
`define ASU_TXST_BF 1
`define ASU_TXST_SF 0

// ****************************************
// Reset values and codes
// ****************************************
`define ASU_MODE_RST 8'h01
`define ASU_CTRL_RST 8'h16
`define ASU_DIV_RST 8'hFF
`define ASU_PAR_NONE 2'h0
`define ASU_PAR_ZERO 2'h1
`define ASU_PAR_ODD 2'h2
`define ASU_PAR_EVEN 2'h3
`define ASU_LAST_8BIT 3'h7
`define ASU_LAST_7BIT 3'h6
`define ASU_MASK_8BIT 8'hFF
`define ASU_MASK_7BIT 8'h7F

`endif

// ===== core/asu_pkg.sv
// Types shared by the async serial unit
package asu_pkg;

  // ****************************************
  // Register port request
  // ****************************************
  typedef struct packed {
    logic [15:0] addr; // Byte address
    logic [7:0] wdata; // Write data
    logic wr; // Write strobe
    logic rd; // Read strobe
  } asu_reg_req_type;

  // ****************************************
  // Frame sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ASU_IDLE,
    ASU_START,
    ASU_DATA,
    ASU_PAR,
    ASU_STOP
  } asu_state_type;

endpackage

// ===== core/asu_top.sv
// Async serial unit: mode registers, transmit FIFO, frame transmitter and receiver
// Notes on behaviour
// RQ1: All three bits clear means stop mode.
// RQ2: Mode register resets to 01H.
// RQ3: Power off stops and resets unit internals.
// RQ4: Transmit enable off resets transmitter synchronously.
// RQ5: Receive enable off resets receiver synchronously.
// RQ6: Power off: output high, input seen high.
// RQ7: Power off clears status, break bits, buffer.
// RQ8: Software sequences power and enables correctly.
// RQ9: One byte per frame, full duplex.
// RQ10: Software configures in order; buffer write sends.
// RQ11: Pins owned only when powered and enabled.
// RQ12: Start, 7/8 bits, optional parity, 1/2 stops.
// RQ13: Length, parity, stops from mode register.
// RQ14: Control bit 1 picks LSB or MSB first.
// RQ15: Control bit 0 inverts serial output.
// RQ16: Even parity transmit makes total ones even.
// RQ17: Even parity receive errors on odd count.
// RQ18: Odd parity transmit makes total ones odd.
// RQ19: Odd parity receive errors on even count.
// RQ20: Zero parity sends 0, never checks.
// RQ21: No parity: no bit, no error.
// RQ22: Software keeps parity zero on LIN.
// RQ23: Transmit done pulses right after last stop.
// RQ24: Receiver checks only one stop bit.
// RQ25: Software disables before changing order/polarity.
// RQ26: Parity follows data; line idles high.
`timescale 1ns/1ps
`include "asu_defines.svh"

// ****************************************
// Synchronous FIFO
// ****************************************
module asu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clr, // Sync clear
  input wire logic in_valid, // Push request
  output logic in_ready, // Not full
  input wire logic [WIDTH-1:0] in_data, // Push data
  output logic out_valid, // Not empty
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wp_r; // Write pointer
  logic [AW-1:0] rp_r; // Read pointer
  logic [AW:0] cnt_r; // Fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (32'(cnt_r) != DEPTH); // Full only at DEPTH words
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= push ? AW'(32'(wp_r) + 1 == DEPTH ? 0 : 32'(wp_r) + 1) : wp_r;
      rp_r <= pop ? AW'(32'(rp_r) + 1 == DEPTH ? 0 : 32'(rp_r) + 1) : rp_r;
      cnt_r <= (AW+1)'(32'(cnt_r) + 32'(push) - 32'(pop));
    end
  end
endmodule // asu_fifo

// ****************************************
// Top
// ****************************************
module asu_top #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst_b, // Chip reset, active low
  input wire asu_pkg::asu_reg_req_type reg_req, // Register access
  output logic [7:0] reg_rdata, // Read data, one cycle after rd
  input wire logic serial_in_pin, // Receive line
  output logic serial_out_pin, // Transmit line level
  output logic serial_out_sel, // Output pin owned by unit
  output logic serial_in_sel, // Input pin owned by unit
  output logic tx_buf_ready, // Transmit FIFO can take a byte
  output logic transmit_done_irq, // Frame sent pulse
  output logic receive_done_irq // Frame received pulse
);
  import asu_pkg::*;

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [7:0] mode_r; // Operation mode
  logic [5:0] ctrl_r; // Control low bits
  logic brk_r; // Break trigger pending
  logic [7:0] div_r; // Baud divisor
  logic [2:0] err_r; // Receive error status
  logic [7:0] rxb_r; // Receive buffer
  logic rx_full_r; // Receive buffer unread
  logic [7:0] rdata_r; // Read data
  logic seen_mode_wr_r; // Mode written since reset

  wire wr_mode = reg_req.wr && (reg_req.addr == `ASU_OFS_MODE);
  wire wr_ctrl = reg_req.wr && (reg_req.addr == `ASU_OFS_CTRL);
  wire wr_div = reg_req.wr && (reg_req.addr == `ASU_OFS_DIV);
  wire wr_txb = reg_req.wr && (reg_req.addr == `ASU_OFS_TXB);
  wire rd_rxb = reg_req.rd && (reg_req.addr == `ASU_OFS_RXB);
  wire rd_err = reg_req.rd && (reg_req.addr == `ASU_OFS_ERR);
  wire power = mode_r[`ASU_MODE_POWER];
  wire tx_on = power && mode_r[`ASU_MODE_TXE]; // see RQ11
  wire rx_on = power && mode_r[`ASU_MODE_RXE]; // see RQ11
  wire unit_rst_b = rst_b && power; // see RQ3
  wire [1:0] par_mode = mode_r[`ASU_MODE_PSH:`ASU_MODE_PSL]; // see RQ13
  wire [2:0] char_last = mode_r[`ASU_MODE_CL] ? `ASU_LAST_8BIT : `ASU_LAST_7BIT; // see RQ12
  wire [7:0] char_mask = mode_r[`ASU_MODE_CL] ? `ASU_MASK_8BIT : `ASU_MASK_7BIT;
  wire lsb_first = ctrl_r[`ASU_CTRL_DIR];
  wire [8:0] bit_last = 9'({div_r, 1'b0} - 9'h001); // Two divisor counts per bit
  wire [8:0] half_last = 9'({1'b0, div_r} - 9'h001);

  // Mode register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= `ASU_MODE_RST; // see RQ2
    end else if (wr_mode) begin
      mode_r <= reg_req.wdata;
    end
  end

  // Control, divisor and mode-write tracker
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 6'(`ASU_CTRL_RST);
      div_r <= `ASU_DIV_RST;
      seen_mode_wr_r <= 1'b0;
    end else begin
      ctrl_r <= wr_ctrl ? reg_req.wdata[5:0] : ctrl_r;
      div_r <= wr_div ? reg_req.wdata : div_r;
      seen_mode_wr_r <= seen_mode_wr_r || wr_mode;
    end
  end

  // Break trigger, held clear while unpowered
  always_ff @(posedge clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      brk_r <= 1'b0; // see RQ7
    end else if (wr_ctrl) begin
      brk_r <= reg_req.wdata[`ASU_CTRL_BRT] && rx_on;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  asu_state_type tx_st_r, tx_st_nxt; // Transmit state
  logic [8:0] tx_cnt_r, tx_cnt_nxt; // Bit timer
  logic [2:0] tx_idx_r, tx_idx_nxt; // Bit index
  logic [7:0] tx_data_r, tx_data_nxt; // Shifting byte
  logic tx_done_r, tx_done_nxt; // Done pulse
  logic tx_out_r; // Registered line level
  logic tx_pop; // FIFO pop
  logic tx_frame_bit; // Current frame bit
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire tx_tick = (tx_cnt_r == bit_last);
  wire [2:0] tx_pos = lsb_first ? tx_idx_r : 3'(char_last - tx_idx_r); // see RQ14
  wire tx_ones = ^(tx_data_r & char_mask);
  wire tx_par = (par_mode == `ASU_PAR_EVEN) ? tx_ones : // see RQ16
                (par_mode == `ASU_PAR_ODD) ? !tx_ones : 1'b0; // see RQ18 // see RQ20
  wire [2:0] stop_last = {2'b00, mode_r[`ASU_MODE_SL]};

  asu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
    .clk(clk),
    .rst_b(unit_rst_b),
    .clr(!mode_r[`ASU_MODE_TXE]),
    .in_valid(wr_txb),
    .in_ready(tx_buf_ready),
    .in_data(reg_req.wdata),
    .out_valid(fifo_valid),
    .out_ready(tx_pop),
    .out_data(fifo_data)
  );

  // Frame bit chosen by state; idle and stop are high
  always_comb begin
    case (tx_st_r)
      ASU_START: tx_frame_bit = 1'b0;
      ASU_DATA: tx_frame_bit = tx_data_r[tx_pos];
      ASU_PAR: tx_frame_bit = tx_par; // see RQ26
      default: tx_frame_bit = 1'b1; // see RQ26
    endcase
  end

  // Transmit sequencer
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_idx_nxt = tx_idx_r;
    tx_data_nxt = tx_data_r;
    tx_done_nxt = 1'b0;
    tx_pop = 1'b0;
    tx_cnt_nxt = (tx_tick || tx_st_r == ASU_IDLE) ? 9'h000 : 9'(tx_cnt_r + 9'h001);
    case (tx_st_r)
      ASU_IDLE: begin
        if (fifo_valid && tx_on) begin // see RQ10
          tx_pop = 1'b1;
          tx_data_nxt = fifo_data;
          tx_st_nxt = ASU_START;
        end
      end
      ASU_START: begin
        if (tx_tick) begin
          tx_st_nxt = ASU_DATA;
          tx_idx_nxt = 3'h0;
        end
      end
      ASU_DATA: begin
        if (tx_tick && tx_idx_r == char_last) begin // see RQ12
          tx_st_nxt = (par_mode == `ASU_PAR_NONE) ? ASU_STOP : ASU_PAR; // see RQ21
          tx_idx_nxt = 3'h0;
        end else if (tx_tick) begin
          tx_idx_nxt = 3'(tx_idx_r + 3'h1);
        end
      end
      ASU_PAR: begin
        if (tx_tick) begin
          tx_st_nxt = ASU_STOP;
        end
      end
      ASU_STOP: begin
        if (tx_tick && tx_idx_r == stop_last) begin
          tx_st_nxt = ASU_IDLE;
          tx_done_nxt = 1'b1; // see RQ23
        end else if (tx_tick) begin
          tx_idx_nxt = 3'(tx_idx_r + 3'h1);
        end
      end
      default: tx_st_nxt = ASU_IDLE;
    endcase
  end

  // Transmit state, cleared synchronously when disabled
  always_ff @(posedge clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_st_r <= ASU_IDLE;
      tx_cnt_r <= 9'h000;
      tx_idx_r <= 3'h0;
      tx_data_r <= 8'h00;
      tx_done_r <= 1'b0;
    end else if (!mode_r[`ASU_MODE_TXE]) begin
      tx_st_r <= ASU_IDLE; // see RQ4
      tx_cnt_r <= 9'h000;
      tx_idx_r <= 3'h0;
      tx_done_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_data_r <= tx_data_nxt;
      tx_done_r <= tx_done_nxt;
    end
  end

  // Output line, high while unpowered
  always_ff @(posedge clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_out_r <= 1'b1; // see RQ6
    end else begin
      tx_out_r <= tx_frame_bit ^ ctrl_r[`ASU_CTRL_INV]; // see RQ15
    end
  end

  assign serial_out_pin = tx_out_r;
  assign serial_out_sel = tx_on; // see RQ1
  assign serial_in_sel = rx_on; // see RQ1
  assign transmit_done_irq = tx_done_r;

  // ****************************************
  // Receive path
  // ****************************************
  asu_state_type rx_st_r, rx_st_nxt; // Receive state
  logic [8:0] rx_cnt_r, rx_cnt_nxt; // Bit timer
  logic [2:0] rx_idx_r, rx_idx_nxt; // Bit index
  logic [7:0] rx_sh_r, rx_sh_nxt; // Assembled character
  logic rx_par_r, rx_par_nxt; // Received parity bit
  logic rx_end; // Stop bit sampled
  logic rx_done_r; // Done pulse
  wire rx_line = rx_on ? serial_in_pin : 1'b1; // see RQ6
  wire rx_tick = (rx_cnt_r == bit_last);
  wire [2:0] rx_pos = lsb_first ? rx_idx_r : 3'(char_last - rx_idx_r); // see RQ14
  wire rx_ones = ^(rx_sh_r & char_mask) ^ rx_par_r;
  wire rx_pe = ((par_mode == `ASU_PAR_EVEN) && rx_ones) || // see RQ17
               ((par_mode == `ASU_PAR_ODD) && !rx_ones); // see RQ19 // see RQ20
  wire rx_fe = !rx_line; // see RQ24
  wire rx_ove = rx_full_r && !rd_rxb;

  // Receive sequencer; centre of start found after half a bit
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_idx_nxt = rx_idx_r;
    rx_sh_nxt = rx_sh_r;
    rx_par_nxt = rx_par_r;
    rx_end = 1'b0;
    rx_cnt_nxt = (rx_tick || rx_st_r == ASU_IDLE) ? 9'h000 : 9'(rx_cnt_r + 9'h001);
    case (rx_st_r)
      ASU_IDLE: begin
        if (!rx_line) begin
          rx_st_nxt = ASU_START;
          rx_sh_nxt = 8'h00;
        end
      end
      ASU_START: begin
        if (rx_cnt_r == half_last) begin
          rx_st_nxt = rx_line ? ASU_IDLE : ASU_DATA;
          rx_cnt_nxt = 9'h000;
          rx_idx_nxt = 3'h0;
        end
      end
      ASU_DATA: begin
        if (rx_tick) begin
          rx_sh_nxt[rx_pos] = rx_line; // see RQ9
          rx_idx_nxt = 3'(rx_idx_r + 3'h1);
          if (rx_idx_r == char_last) begin
            rx_st_nxt = (par_mode == `ASU_PAR_NONE) ? ASU_STOP : ASU_PAR; // see RQ21
          end
        end
      end
      ASU_PAR: begin
        if (rx_tick) begin
          rx_par_nxt = rx_line;
          rx_st_nxt = ASU_STOP;
        end
      end
      ASU_STOP: begin
        if (rx_tick) begin
          rx_end = 1'b1; // see RQ24
          rx_st_nxt = ASU_IDLE;
        end
      end
      default: rx_st_nxt = ASU_IDLE;
    endcase
  end

  // Receive state, cleared synchronously when disabled
  always_ff @(posedge clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_st_r <= ASU_IDLE;
      rx_cnt_r <= 9'h000;
      rx_idx_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else if (!mode_r[`ASU_MODE_RXE]) begin
      rx_st_r <= ASU_IDLE; // see RQ5
      rx_cnt_r <= 9'h000;
      rx_idx_r <= 3'h0;
      rx_done_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_par_r <= (par_mode == `ASU_PAR_NONE) ? 1'b0 : rx_par_nxt;
      rx_done_r <= rx_end;
    end
  end

  // Buffer and error flags; a new event wins over a read clear
  always_ff @(posedge clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rxb_r <= 8'h00; // see RQ7
      rx_full_r <= 1'b0;
      err_r <= 3'h0;
    end else begin
      rxb_r <= (rx_end && !rx_ove) ? rx_sh_r : rxb_r;
      rx_full_r <= rx_end || (rx_full_r && !rd_rxb);
      err_r <= rx_end ? {rx_pe, rx_fe, rx_ove} | (rd_err ? 3'h0 : err_r) :
                        (rd_err ? 3'h0 : err_r);
    end
  end

  assign receive_done_irq = rx_done_r;

  // ****************************************
  // Read port
  // ****************************************
  wire [7:0] txst_val = {6'h00, fifo_valid, tx_st_r != ASU_IDLE};
  wire [7:0] ctrl_val = {brk_r, 1'b0, ctrl_r};
  wire [7:0] rd_val = (reg_req.addr == `ASU_OFS_MODE) ? mode_r :
                      (reg_req.addr == `ASU_OFS_CTRL) ? ctrl_val :
                      (reg_req.addr == `ASU_OFS_DIV) ? div_r :
                      (reg_req.addr == `ASU_OFS_RXB) ? rxb_r :
                      (reg_req.addr == `ASU_OFS_ERR) ? {5'h00, err_r} :
                      (reg_req.addr == `ASU_OFS_TXST) ? txst_val : 8'h00;

  // Read data register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      rdata_r <= rd_val;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_stop_mode_pins: assert property (!power |-> serial_out_pin && !serial_out_sel && !serial_in_sel) // see RQ6
    else $error("stop mode pins wrong");
  chk_mode_reset_val: assert property (!seen_mode_wr_r |-> mode_r == `ASU_MODE_RST) // see RQ2
    else $error("mode reset value wrong");
  chk_power_off_clear: assert property (!power |-> err_r == 3'h0 && !rx_full_r && tx_st_r == ASU_IDLE) // see RQ7
    else $error("state not cleared while unpowered");
  chk_txe_sync_rst: assert property (power && !mode_r[`ASU_MODE_TXE] |=> tx_st_r == ASU_IDLE) // see RQ4
    else $error("transmitter not reset");
  chk_rxe_sync_rst: assert property (power && !mode_r[`ASU_MODE_RXE] |=> rx_st_r == ASU_IDLE) // see RQ5
    else $error("receiver not reset");
  chk_start_bit_level: assert property (tx_st_r == ASU_START && power |=> serial_out_pin == ctrl_r[`ASU_CTRL_INV]) // see RQ15
    else $error("start bit level wrong");
  chk_done_after_stop: assert property ($rose(transmit_done_irq) |-> $past(tx_st_r) == ASU_STOP && tx_st_r == ASU_IDLE) // see RQ23
    else $error("done pulse not after stop");
  chk_no_parity_err: assert property (par_mode[1] == 1'b0 |-> !$rose(err_r[`ASU_ERR_PE])) // see RQ20
    else $error("parity error without check");
  chk_parity_tx_bit: assert property (tx_st_r == ASU_PAR && power |=> // see RQ16
    serial_out_pin == ((($past(par_mode) == `ASU_PAR_ZERO) ? 1'b0 :
    ($past(tx_ones) ^ ($past(par_mode) == `ASU_PAR_ODD))) ^ ctrl_r[`ASU_CTRL_INV])) // see RQ20
    else $error("parity bit wrong");

  cov_tx_frame: cover property (transmit_done_irq);
  cov_rx_frame: cover property (receive_done_irq);
  cov_parity_err: cover property ($rose(err_r[`ASU_ERR_PE]));
  cov_fifo_full: cover property (!tx_buf_ready && power);
endmodule // asu_top

// ===== core/asu_fifo_note.sv
// The transmit FIFO module sits in asu_top.sv beside the unit that uses it

// ===== verification/asu_peer.sv
// Remote serial node model: frame sender and frame capturer
`timescale 1ns/1ps

// ****************************************
// Remote node
// ****************************************
module asu_peer (
  input wire logic clk, // Bench clock
  input wire logic line_in, // Line from the unit
  output logic line_out // Line to the unit
);
  int bit_clks = 4; // Clocks per bit at divisor 2

  // Line idles high between frames
  initial line_out = 1'b1;

  // Start, data, optional parity, one stop only
  task automatic send(input logic [7:0] d, input int n, input logic lsb, input logic has_par,
                      input logic par);
    logic b[$];
    b.push_back(1'b0);
    for (int i = 0; i < n; i++) b.push_back(lsb ? d[i] : d[n - 1 - i]);
    if (has_par) b.push_back(par);
    b.push_back(1'b1);
    foreach (b[i]) begin
      #1 line_out = b[i];
      repeat (bit_clks) @(posedge clk);
    end
  endtask

  // Capture one frame at mid-bit, undoing output inversion
  task automatic recv(input int n, input logic lsb, input logic has_par, input logic inv,
                      output logic [7:0] d, output logic par, output logic stop);
    d = 8'h00;
    par = 1'b0;
    wait ((line_in ^ inv) == 1'b0);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge clk);
      if (lsb) d[i] = line_in ^ inv;
      else d[n - 1 - i] = line_in ^ inv;
    end
    if (has_par) begin
      repeat (bit_clks) @(posedge clk);
      par = line_in ^ inv;
    end
    repeat (bit_clks) @(posedge clk);
    stop = line_in ^ inv;
  endtask
endmodule // asu_peer

// ===== verification/async_serial_mode_and_frame_control_tb.sv
// Self-checking bench of the async serial unit
`timescale 1ns/1ps
`include "asu_defines.svh"

// ****************************************
// Bench top
// ****************************************
module async_serial_mode_and_frame_control_tb;
  import asu_pkg::*;
  logic clk; // Clock
  logic rst_b; // Reset, active low
  asu_reg_req_type req; // Register request
  logic [7:0] reg_rdata; // Read data
  logic rx_line; // Line into the unit
  logic tx_line; // Line out of the unit
  logic out_sel; // Output pin owned
  logic in_sel; // Input pin owned
  logic buf_ready; // Room in transmit FIFO
  logic tx_done; // Frame sent pulse
  logic rx_done; // Frame received pulse
  int failures; // Mismatches
  int checked; // Comparisons
  int cycles; // Timeout counter

  asu_top #(.FIFO_DEPTH(8)) dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(reg_rdata),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line), .serial_out_sel(out_sel),
    .serial_in_sel(in_sel), .tx_buf_ready(buf_ready), .transmit_done_irq(tx_done),
    .receive_done_irq(rx_done));
  asu_peer peer (.clk(clk), .line_in(tx_line), .line_out(rx_line));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks made %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    #1 req.wr = 1'b0;
  endtask

  // Register read, data held after the strobe
  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 req = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    #1 req.rd = 1'b0;
    chk(what, exp, reg_rdata);
  endtask

  // Bounded wait for a done pulse
  task automatic wait_pulse(input logic tx, input string what);
    int k;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      #1;
      if ((tx ? tx_done : rx_done) === 1'b1) break;
    end
    chk(what, 8'h01, {7'h00, k < 100});
  endtask

  // Expected parity bit of a masked character
  function automatic logic exp_par(input logic [7:0] d, input logic [1:0] pm);
    return (pm == `ASU_PAR_ZERO) ? 1'b0 : (pm == `ASU_PAR_ODD) ? ~^d : ^d;
  endfunction

  // Format, control, power, then enables
  task automatic setup(input logic [4:0] fmt, input logic [1:0] ctl);
    wr(`ASU_OFS_MODE, {3'b000, fmt});
    wr(`ASU_OFS_CTRL, {6'h05, ctl});
    wr(`ASU_OFS_MODE, {3'b100, fmt});
    wr(`ASU_OFS_MODE, {3'b111, fmt});
  endtask

  // Main sequence
  initial begin
    logic [7:0] d, e, v;
    logic [1:0] ctl;
    logic p, s, bad;
    int n;
    req = '0;
    rst_b = 1'b0;
    void'($urandom(80));
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    rdchk("mode", `ASU_OFS_MODE, `ASU_MODE_RST);
    rdchk("ctrl", `ASU_OFS_CTRL, `ASU_CTRL_RST);
    rdchk("unmapped", 16'hFF5F, 8'h00);
    chk("stop pins", 8'h01, {6'h00, out_sel | in_sel, tx_line});
    wr(`ASU_OFS_DIV, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(`ASU_OFS_MODE, {i[2:0], 5'h01});
      chk("owner", {6'h00, i[2] & i[1], i[2] & i[0]}, {6'h00, out_sel, in_sel});
    end
    wr(`ASU_OFS_MODE, 8'h81);
    // Every parity, length, stop count, order and polarity
    for (int t = 0; t < 16; t++) begin
      ctl = {t[0] ^ t[3], t[1] ^ t[2]};
      n = t[2] ? 8 : 7;
      setup({t[1:0], t[2], t[3], 1'b1}, ctl);
      rdchk("ctrl rw", `ASU_OFS_CTRL, {6'h05, ctl});
      chk("idle", {7'h00, ~ctl[0]}, {7'h00, tx_line});
      d = 8'($urandom);
      d = t[2] ? d : {1'b0, d[6:0]};
      e = 8'($urandom);
      e = t[2] ? e : {1'b0, e[6:0]};
      bad = 1'($urandom % 2);
      wr(`ASU_OFS_TXB, d);
      fork
        begin
          peer.recv(n, ctl[1], t[1:0] != 0, ctl[0], v, p, s);
          wait_pulse(1'b1, "tx done");
        end
        peer.send(e, n, ctl[1], t[1:0] != 0, exp_par(e, t[1:0]) ^ bad);
        wait_pulse(1'b0, "rx done");
      join
      chk("tx data", d, v);
      chk("tx parity", {7'h00, t[1:0] != 0 && exp_par(d, t[1:0])}, {7'h00, p});
      chk("tx stop", 8'h01, {7'h00, s});
      rdchk("rx error", `ASU_OFS_ERR, {5'h00, bad & t[1], 2'b00});
      rdchk("rx data", `ASU_OFS_RXB, e);
      wr(`ASU_OFS_MODE, {3'b100, t[1:0], t[2], t[3], 1'b1});
    end
    // Fill the FIFO until it refuses, then drain it
    setup(5'b00111, 2'b10);
    fork
      begin
        for (int i = 0; i < 10; i++) wr(`ASU_OFS_TXB, 8'(i + 8'hA0));
        chk("fifo full", 8'h00, {7'h00, buf_ready});
      end
      for (int i = 0; i < 9; i++) begin
        peer.recv(8, 1'b1, 1'b0, 1'b0, v, p, s);
        chk("burst data", 8'(i + 8'hA0), v);
      end
    join
    wait_pulse(1'b1, "last done");
    rdchk("tx idle", `ASU_OFS_TXST, 8'h00);
    // Abort a frame, then receive one frame and leave it unread
    wr(`ASU_OFS_TXB, 8'h00);
    repeat (8) @(posedge clk);
    wr(`ASU_OFS_MODE, 8'hA7);
    rdchk("tx abort", `ASU_OFS_TXST, 8'h00);
    fork
      peer.send(8'h3C, 8, 1'b1, 1'b0, 1'b0);
      wait_pulse(1'b0, "rx late");
    join
    // Break trigger with order and polarity refreshed unchanged
    wr(`ASU_OFS_CTRL, 8'h56);
    rdchk("break set", `ASU_OFS_CTRL, 8'h96);
    // Second frame onto an unread buffer
    fork
      peer.send(8'hC3, 8, 1'b1, 1'b0, 1'b0);
      wait_pulse(1'b0, "rx again");
    join
    rdchk("rx overrun", `ASU_OFS_ERR, 8'h01);
    rdchk("rx kept", `ASU_OFS_RXB, 8'h3C);
    wr(`ASU_OFS_MODE, 8'h87);
    wr(`ASU_OFS_MODE, 8'h07);
    rdchk("rxb off", `ASU_OFS_RXB, 8'h00);
    rdchk("ctrl off", `ASU_OFS_CTRL, 8'h16);
    chk("off pins", 8'h01, {6'h00, out_sel | in_sel, tx_line});
    finish_test();
  end
endmodule // async_serial_mode_and_frame_control_tb
